// File: hw/mbs_pkg.sv
// package for the motor brake sequencer: settings map, fields, reset values, timing
package mbs_pkg;

  // register byte offsets
  localparam logic [7:0] MBS_OFF_CTRL    = 8'h00;
  localparam logic [7:0] MBS_OFF_CUR_UP  = 8'h04;
  localparam logic [7:0] MBS_OFF_CUR_LO  = 8'h08;
  localparam logic [7:0] MBS_OFF_FRQ_REL = 8'h0C;
  localparam logic [7:0] MBS_OFF_FRQ_APL = 8'h10;
  localparam logic [7:0] MBS_OFF_DLY_MAG = 8'h14;
  localparam logic [7:0] MBS_OFF_DLY_PST = 8'h18;
  localparam logic [7:0] MBS_OFF_DLY_APL = 8'h1C;
  localparam logic [7:0] MBS_OFF_STATUS  = 8'h20;

  // control register field positions
  localparam int MBS_CTRL_SEL_LSB  = 0;
  localparam int MBS_CTRL_SAFE_BIT = 4;
  localparam int MBS_CTRL_MODE_LSB = 8;
  localparam int MBS_CTRL_OPEN_BIT = 12;

  // brake selector encodings
  typedef enum logic [1:0] {
    MBS_SEL_OFF     = 2'b00,
    MBS_SEL_CONTACT = 2'b01,
    MBS_SEL_RELAY   = 2'b10,
    MBS_SEL_USER    = 2'b11
  } mbs_sel_t;

  // control mode encodings
  typedef enum logic [1:0] {
    MBS_MODE_OPEN_LOOP = 2'b00,
    MBS_MODE_CL_VECTOR = 2'b01,
    MBS_MODE_CL_SERVO  = 2'b10
  } mbs_mode_t;

  // sequencer states
  typedef enum logic [2:0] {
    MBS_ST_APPLIED = 3'b000,
    MBS_ST_MAGNET  = 3'b001,
    MBS_ST_POST    = 3'b010,
    MBS_ST_RUN     = 3'b011,
    MBS_ST_PREAPL  = 3'b100,
    MBS_ST_HOLD    = 3'b101
  } mbs_state_t;

  // reset and factory values
  localparam logic [15:0] MBS_RST_CUR_UP  = 16'h0032;
  localparam logic [15:0] MBS_RST_CUR_LO  = 16'h000A;
  localparam logic [15:0] MBS_RST_FRQ_REL = 16'h000A;
  localparam logic [15:0] MBS_RST_FRQ_APL = 16'h0014;
  localparam logic [15:0] MBS_RST_DLY_MAG = 16'h012C;
  localparam logic [15:0] MBS_RST_DLY_PST = 16'h012C;
  localparam logic [15:0] MBS_RST_DLY_APL = 16'h012C;

  // delay tick: settings count in ms
  localparam int MBS_CLK_HZ      = 10_000_000;
  localparam int MBS_TICK_US     = 1000;
  localparam int MBS_TICK_CYCLES = MBS_CLK_HZ / 1_000_000 * MBS_TICK_US;

  // drive measurements bundle
  typedef struct packed {
    logic [15:0] current;
    logic [15:0] freq;
    logic        run_req;
    logic        stop_req;
  } mbs_meas_t;

  // output routing bundle
  typedef struct packed {
    logic contactor;
    logic relay;
    logic spare_io;
    logic user_cmd;
  } mbs_route_t;

endpackage

// File: hw/mbs_delay.sv
// one-shot millisecond delay timer used by the brake sequencer
`timescale 1ns/1ps
`default_nettype none
module mbs_delay #(
  parameter int TICK_CYCLES = mbs_pkg::MBS_TICK_CYCLES
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // control
  input  wire logic        i_start,
  input  wire logic        i_abort,
  input  wire logic [15:0] i_len_ms,
  // status
  output logic             o_done
);

  logic [15:0] ms_ff;
  logic [23:0] tick_ff;
  logic        busy_ff;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_ff <= 1'b0;
      ms_ff   <= 16'h0000;
      tick_ff <= 24'h000000;
      o_done  <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_abort) begin
        busy_ff <= 1'b0;
      end else if (i_start) begin
        busy_ff <= 1'b1;
        ms_ff   <= i_len_ms;
        tick_ff <= 24'h000000;
      end else if (busy_ff) begin
        if (ms_ff == 16'h0000) begin
          busy_ff <= 1'b0;
          o_done  <= 1'b1;
        end else if (tick_ff == 24'(TICK_CYCLES - 1)) begin
          tick_ff <= 24'h000000;
          ms_ff   <= ms_ff - 16'h0001;
        end else begin
          tick_ff <= tick_ff + 24'h000001;
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: hw/mbs_top.sv
// motor brake sequencer top: ahb-lite settings slave, release/apply sequencing, routing
// Overview of operation
// - selector off: no brake command, settings ignored
// - contactor route drives option contactor output
// - relay route: brake on relay, fault to spare
// - user route: command only on user output
// - relay plus secure safe input becomes user
// - writing relay route forces open setting flag
// - current at upper threshold allows release
// - current below lower threshold applies brake
// - frequency at release threshold allows release
// - stop and below apply threshold applies
// - below apply threshold without stop keeps released
// - magnetisation delay precedes brake release
// - ramp frozen during magnetisation delay
// - pre-release delay postpones apply after threshold in closed-loop modes
// - post-release delay keeps ramp locked
// - apply delay holds torque, then output off
// - loop family change restores apply threshold, magnetisation delay
`timescale 1ns/1ps
`default_nettype none
module mbs_top #(
  parameter int TICK_CYCLES = mbs_pkg::MBS_TICK_CYCLES
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  // ahb-lite slave
  input  wire logic             i_hsel,
  input  wire logic [7:0]       i_haddr,
  input  wire logic [1:0]       i_htrans,
  input  wire logic             i_hwrite,
  input  wire logic [2:0]       i_hsize,
  input  wire logic [31:0]      i_hwdata,
  input  wire logic             i_hready,
  output logic [31:0]           o_hrdata,
  output logic                  o_hreadyout,
  output logic                  o_hresp,
  // drive measurements, same clock
  input  wire mbs_pkg::mbs_meas_t i_meas,
  input  wire logic             i_fault,
  // outputs
  output mbs_pkg::mbs_route_t   o_route,
  output logic                  o_fault_relay,
  output logic                  o_ramp_hold,
  output logic                  o_power_off
);

  // settings
  mbs_pkg::mbs_sel_t  sel_ff;
  logic               safe_secure_ff;
  mbs_pkg::mbs_mode_t mode_ff;
  logic               open_set_ff;
  logic [15:0]        cur_up_ff;
  logic [15:0]        cur_lo_ff;
  logic [15:0]        frq_rel_ff;
  logic [15:0]        frq_apl_ff;
  logic [15:0]        dly_mag_ff;
  logic [15:0]        dly_pst_ff;
  logic [15:0]        dly_apl_ff;

  // bus address phase capture
  logic               wr_pend_ff;
  logic [7:0]         addr_ff;

  // sequencer
  mbs_pkg::mbs_state_t state_ff;
  mbs_pkg::mbs_state_t nxt_state;
  logic               brake_cmd_ff;
  logic               t_start;
  logic               t_abort;
  logic [15:0]        t_len;
  logic               t_done;

  function automatic logic is_open(input mbs_pkg::mbs_mode_t m);
    return m == mbs_pkg::MBS_MODE_OPEN_LOOP;
  endfunction

  wire logic active    = sel_ff != mbs_pkg::MBS_SEL_OFF;
  wire logic cur_hi    = i_meas.current >= cur_up_ff;
  wire logic cur_loss  = i_meas.current < cur_lo_ff;
  wire logic frq_ok    = i_meas.freq >= frq_rel_ff;
  wire logic frq_low   = i_meas.freq < frq_apl_ff;
  wire logic rel_conds = i_meas.run_req && !i_meas.stop_req && cur_hi && frq_ok;
  wire logic addr_ph   = i_hsel && i_hready && i_htrans[1];
  wire logic [31:0] wd = i_hwdata;
  wire mbs_pkg::mbs_sel_t wsel = mbs_pkg::mbs_sel_t'(wd[mbs_pkg::MBS_CTRL_SEL_LSB +: 2]);
  wire mbs_pkg::mbs_mode_t wmode = mbs_pkg::mbs_mode_t'(wd[mbs_pkg::MBS_CTRL_MODE_LSB +: 2]);
  wire logic wsafe     = wd[mbs_pkg::MBS_CTRL_SAFE_BIT];
  wire logic ctrl_wr   = wr_pend_ff && addr_ff == mbs_pkg::MBS_OFF_CTRL;

  // bus front end: zero wait states, always okay
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_pend_ff  <= 1'b0;
      addr_ff     <= 8'h00;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      wr_pend_ff <= addr_ph && i_hwrite;
      if (addr_ph) begin
        addr_ff <= {i_haddr[7:2], 2'b00};
      end
    end
  end

  // control register: selector, safe input, mode, open flag
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sel_ff         <= mbs_pkg::MBS_SEL_OFF;
      safe_secure_ff <= 1'b0;
      mode_ff        <= mbs_pkg::MBS_MODE_OPEN_LOOP;
      open_set_ff    <= 1'b0;
    end else if (ctrl_wr) begin
      safe_secure_ff <= wsafe;
      mode_ff        <= wmode;
      if (wsel == mbs_pkg::MBS_SEL_RELAY && wsafe) begin
        sel_ff <= mbs_pkg::MBS_SEL_USER;
      end else begin
        sel_ff <= wsel;
      end
      if (wsel == mbs_pkg::MBS_SEL_RELAY) begin
        open_set_ff <= 1'b1;
      end else begin
        open_set_ff <= wd[mbs_pkg::MBS_CTRL_OPEN_BIT];
      end
    end
  end

  // thresholds and delays; loop family change restores apply threshold and magnetisation delay
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cur_up_ff  <= mbs_pkg::MBS_RST_CUR_UP;
      cur_lo_ff  <= mbs_pkg::MBS_RST_CUR_LO;
      frq_rel_ff <= mbs_pkg::MBS_RST_FRQ_REL;
      frq_apl_ff <= mbs_pkg::MBS_RST_FRQ_APL;
      dly_mag_ff <= mbs_pkg::MBS_RST_DLY_MAG;
      dly_pst_ff <= mbs_pkg::MBS_RST_DLY_PST;
      dly_apl_ff <= mbs_pkg::MBS_RST_DLY_APL;
    end else if (ctrl_wr && is_open(wmode) != is_open(mode_ff)) begin
      frq_apl_ff <= mbs_pkg::MBS_RST_FRQ_APL;
      dly_mag_ff <= mbs_pkg::MBS_RST_DLY_MAG;
    end else if (wr_pend_ff) begin
      case (addr_ff)
        mbs_pkg::MBS_OFF_CUR_UP:  cur_up_ff  <= wd[15:0];
        mbs_pkg::MBS_OFF_CUR_LO:  cur_lo_ff  <= wd[15:0];
        mbs_pkg::MBS_OFF_FRQ_REL: frq_rel_ff <= wd[15:0];
        mbs_pkg::MBS_OFF_FRQ_APL: frq_apl_ff <= wd[15:0];
        mbs_pkg::MBS_OFF_DLY_MAG: dly_mag_ff <= wd[15:0];
        mbs_pkg::MBS_OFF_DLY_PST: dly_pst_ff <= wd[15:0];
        mbs_pkg::MBS_OFF_DLY_APL: dly_apl_ff <= wd[15:0];
        default: ;
      endcase
    end
  end

  // read data registered in the address phase; unmapped reads zero
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_hrdata <= 32'h00000000;
    end else if (addr_ph && !i_hwrite) begin
      case ({i_haddr[7:2], 2'b00})
        mbs_pkg::MBS_OFF_CTRL:    o_hrdata <= {19'h00000, open_set_ff, 2'b00, mode_ff,
                                               3'b000, safe_secure_ff, 2'b00, sel_ff};
        mbs_pkg::MBS_OFF_CUR_UP:  o_hrdata <= {16'h0000, cur_up_ff};
        mbs_pkg::MBS_OFF_CUR_LO:  o_hrdata <= {16'h0000, cur_lo_ff};
        mbs_pkg::MBS_OFF_FRQ_REL: o_hrdata <= {16'h0000, frq_rel_ff};
        mbs_pkg::MBS_OFF_FRQ_APL: o_hrdata <= {16'h0000, frq_apl_ff};
        mbs_pkg::MBS_OFF_DLY_MAG: o_hrdata <= {16'h0000, dly_mag_ff};
        mbs_pkg::MBS_OFF_DLY_PST: o_hrdata <= {16'h0000, dly_pst_ff};
        mbs_pkg::MBS_OFF_DLY_APL: o_hrdata <= {16'h0000, dly_apl_ff};
        mbs_pkg::MBS_OFF_STATUS:  o_hrdata <= {26'h0000000, o_power_off, o_ramp_hold,
                                               brake_cmd_ff, state_ff};
        default:                  o_hrdata <= 32'h00000000;
      endcase
    end
  end

  // sequencer next state; one shared timer, restarted on each delay state entry
  always_comb begin
    nxt_state = state_ff;
    t_start   = 1'b0;
    t_abort   = 1'b0;
    t_len     = dly_mag_ff;
    if (!active) begin
      nxt_state = mbs_pkg::MBS_ST_APPLIED;
      t_abort   = 1'b1;
    end else begin
      case (state_ff)
        mbs_pkg::MBS_ST_APPLIED: begin
          if (rel_conds) begin
            nxt_state = mbs_pkg::MBS_ST_MAGNET;
            t_start   = 1'b1;
          end
        end
        mbs_pkg::MBS_ST_MAGNET: begin
          if (i_meas.stop_req || cur_loss) begin
            nxt_state = mbs_pkg::MBS_ST_APPLIED;
            t_abort   = 1'b1;
          end else if (t_done) begin
            nxt_state = mbs_pkg::MBS_ST_POST;
            t_start   = 1'b1;
            t_len     = dly_pst_ff;
          end
        end
        mbs_pkg::MBS_ST_POST: begin
          if (cur_loss) begin
            nxt_state = mbs_pkg::MBS_ST_HOLD;
            t_start   = 1'b1;
            t_len     = dly_apl_ff;
          end else if (t_done) begin
            nxt_state = mbs_pkg::MBS_ST_RUN;
          end
        end
        mbs_pkg::MBS_ST_RUN: begin
          if (cur_loss) begin
            nxt_state = mbs_pkg::MBS_ST_HOLD;
            t_start   = 1'b1;
            t_len     = dly_apl_ff;
          end else if (i_meas.stop_req && frq_low) begin
            nxt_state = mbs_pkg::MBS_ST_PREAPL;
            t_start   = 1'b1;
            t_len     = dly_mag_ff;
          end
        end
        mbs_pkg::MBS_ST_PREAPL: begin
          if (cur_loss || (!is_open(mode_ff) && t_done) || is_open(mode_ff)) begin
            nxt_state = mbs_pkg::MBS_ST_HOLD;
            t_start   = 1'b1;
            t_len     = dly_apl_ff;
          end else if (!frq_low) begin
            nxt_state = mbs_pkg::MBS_ST_RUN;
            t_abort   = 1'b1;
          end
        end
        mbs_pkg::MBS_ST_HOLD: begin
          if (t_done) begin
            nxt_state = mbs_pkg::MBS_ST_APPLIED;
          end
        end
        default: begin
          nxt_state = mbs_pkg::MBS_ST_APPLIED;
          t_abort   = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= mbs_pkg::MBS_ST_APPLIED;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // command and ramp lock follow the next state; power output pulses as the hold delay ends
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      brake_cmd_ff <= 1'b0;
      o_ramp_hold  <= 1'b0;
      o_power_off  <= 1'b0;
    end else begin
      brake_cmd_ff <= nxt_state == mbs_pkg::MBS_ST_POST || nxt_state == mbs_pkg::MBS_ST_RUN ||
                      nxt_state == mbs_pkg::MBS_ST_PREAPL;
      o_ramp_hold  <= nxt_state == mbs_pkg::MBS_ST_MAGNET ||
                      nxt_state == mbs_pkg::MBS_ST_POST;
      o_power_off  <= state_ff == mbs_pkg::MBS_ST_HOLD && t_done;
    end
  end

  // routing; fault stays on relay unless relay carries the brake
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_route       <= '0;
      o_fault_relay <= 1'b0;
    end else begin
      o_route.contactor <= sel_ff == mbs_pkg::MBS_SEL_CONTACT && brake_cmd_ff;
      o_route.relay     <= sel_ff == mbs_pkg::MBS_SEL_RELAY && brake_cmd_ff;
      o_route.spare_io  <= sel_ff == mbs_pkg::MBS_SEL_RELAY && i_fault;
      o_route.user_cmd  <= sel_ff == mbs_pkg::MBS_SEL_USER && brake_cmd_ff;
      o_fault_relay     <= sel_ff != mbs_pkg::MBS_SEL_RELAY && i_fault;
    end
  end

  mbs_delay #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_delay (
    .i_clk    (i_clk),
    .i_rst_b  (i_rst_b),
    .i_start  (t_start),
    .i_abort  (t_abort),
    .i_len_ms (t_len),
    .o_done   (t_done)
  );

  // checks
  chk_off_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !active |=> !brake_cmd_ff) else $error("brake command while selector off");
  chk_relay_route: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (sel_ff == mbs_pkg::MBS_SEL_RELAY && brake_cmd_ff && $stable(sel_ff)) |=> o_route.relay)
    else $error("relay not carrying brake");
  chk_secure_user: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (ctrl_wr && wsel == mbs_pkg::MBS_SEL_RELAY && wsafe) |=> sel_ff == mbs_pkg::MBS_SEL_USER)
    else $error("secure relay not moved to user");
  chk_open_flag: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (ctrl_wr && wsel == mbs_pkg::MBS_SEL_RELAY) |=> open_set_ff) else $error("open flag not set");
  chk_loss_apply: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (active && cur_loss && state_ff == mbs_pkg::MBS_ST_RUN) |=> !brake_cmd_ff)
    else $error("brake held on current loss");
  sequence s_release_start;
    active && state_ff == mbs_pkg::MBS_ST_APPLIED && rel_conds;
  endsequence
  chk_mag_first: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_release_start |=> !brake_cmd_ff [*2]) else $error("brake released before delay");
  chk_mag_ramp: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (state_ff == mbs_pkg::MBS_ST_MAGNET && nxt_state == mbs_pkg::MBS_ST_MAGNET) |=> o_ramp_hold)
    else $error("ramp not frozen");
  chk_no_stop_keep: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (active && state_ff == mbs_pkg::MBS_ST_RUN && !i_meas.stop_req && !cur_loss) |=> brake_cmd_ff)
    else $error("brake applied without stop");
  chk_mode_factory: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (ctrl_wr && is_open(wmode) != is_open(mode_ff)) |=> frq_apl_ff == mbs_pkg::MBS_RST_FRQ_APL)
    else $error("apply threshold not restored");

endmodule
`default_nettype wire

// File: dv/mbs_brake_model.sv
// brake contactor model: follows the command after a settable lag
`timescale 1ns/1ps
`default_nettype none
module mbs_brake_model #(
  parameter int LAG = 3
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // command and brake state
  input  wire logic i_cmd,
  output logic      o_open
);
  int cnt;

  // armature lag: a slow brake is still shut while the ramp is held
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt    <= 0;
      o_open <= 1'b0;
    end else if (i_cmd != o_open) begin
      if (cnt >= LAG) begin
        o_open <= i_cmd;
        cnt    <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule
`default_nettype wire

// File: dv/motor_brake_sequencer_tb.sv
// self-checking bench for the brake sequencer top
`timescale 1ns/1ps
`default_nettype none
module motor_brake_sequencer_tb;
  localparam int TICK = 4;
  logic                i_clk = 1'b0;
  logic                i_rst_b = 1'b0;
  logic                hsel, hwrite, fault;
  logic [7:0]          haddr;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic [31:0]         hwdata, hrdata, rd;
  logic                hreadyout, hresp, fault_relay, ramp_hold, power_off;
  logic                brake_fast, brake_slow;
  wire logic           brake_cmd;
  mbs_pkg::mbs_meas_t  meas;
  mbs_pkg::mbs_route_t route;
  int                  errors = 0;
  int                  checked = 0;
  int                  cyc = 0;
  int                  k;

  always #50 i_clk = ~i_clk;
  assign brake_cmd = route.contactor | route.relay | route.user_cmd;

  mbs_top #(.TICK_CYCLES(TICK)) i_dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hreadyout),
    .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp), .i_meas(meas), .i_fault(fault),
    .o_route(route), .o_fault_relay(fault_relay), .o_ramp_hold(ramp_hold), .o_power_off(power_off));
  mbs_brake_model #(.LAG(0)) i_brake_fast (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cmd(brake_cmd), .o_open(brake_fast));
  mbs_brake_model #(.LAG(8)) i_brake_slow (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cmd(brake_cmd), .o_open(brake_slow));

  task automatic wrap_up;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // single word transfer; waits on hready, no assumed latency
  task automatic ahb(input logic wr_en, input logic [7:0] a, input logic [31:0] wd);
    @(posedge i_clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr_en;
    hsize  <= 3'b010;
    do @(posedge i_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge i_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    hwdata <= ~wd;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic set_m(input logic [15:0] cur, input logic [15:0] frq, input logic run, input logic stp);
    @(posedge i_clk);
    meas <= {cur, frq, run, stp};
  endtask

  task automatic wait_route(input int b, input logic v, input int max);
    k = 0;
    while (route[b] !== v && k < max) begin
      @(posedge i_clk);
      k++;
    end
  endtask

  // brings the sequencer back to applied through current loss
  task automatic idle;
    set_m(16'h0000, 16'h0000, 1'b0, 1'b1);
    repeat (40) @(posedge i_clk);
  endtask

  task automatic release_seq(input logic [31:0] ctrl, input int b);
    ahb(1'b1, mbs_pkg::MBS_OFF_CTRL, ctrl);
    set_m(16'h0064, 16'h0064, 1'b1, 1'b0);
    repeat (4) @(posedge i_clk);
    chk("ramp hold magnet", 1, ramp_hold);
    chk("cmd early", 0, route[b]);
    wait_route(b, 1'b1, 60);
    chk("cmd released", 1, route[b]);
    chk("ramp hold post", 1, ramp_hold);
    k = 0;
    while (ramp_hold !== 1'b0 && k < 60) begin
      @(posedge i_clk);
      k++;
    end
    chk("ramp unlocked", 0, ramp_hold);
  endtask

  task automatic t_off;
    ahb(1'b1, mbs_pkg::MBS_OFF_CTRL, 32'h0);
    set_m(16'h0064, 16'h0064, 1'b1, 1'b0);
    repeat (40) @(posedge i_clk);
    chk("route when off", 0, route);
    chk("ramp when off", 0, ramp_hold);
    idle();
  endtask

  task automatic t_cond;
    logic [15:0] cur [3];
    logic [15:0] frq [3];
    logic        run [3];
    cur = '{16'h001E, 16'h0064, 16'h0064};
    frq = '{16'h0064, 16'h0005, 16'h0064};
    run = '{1'b1, 1'b1, 1'b0};
    ahb(1'b1, mbs_pkg::MBS_OFF_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) begin
      set_m(cur[i], frq[i], run[i], 1'b0);
      repeat (20) @(posedge i_clk);
      chk("partial conditions ramp", 0, ramp_hold);
      chk("partial conditions cmd", 0, route);
    end
    idle();
  endtask

  task automatic t_contact;
    release_seq(32'h1, 3);
    set_m(16'h0064, 16'h0005, 1'b1, 1'b0);
    repeat (10) @(posedge i_clk);
    chk("reversal keeps cmd", 1, route.contactor);
    set_m(16'h0064, 16'h0005, 1'b1, 1'b1);
    wait_route(3, 1'b0, 5);
    chk("stop applies", 0, route.contactor);
    k = 0;
    while (power_off !== 1'b1 && k < 60) begin
      @(posedge i_clk);
      k++;
    end
    chk("apply delay then off", 1, (k >= 10) && (power_off === 1'b1));
    chk("brake shut", 0, brake_fast);
    idle();
  endtask

  task automatic t_relay;
    @(posedge i_clk);
    fault <= 1'b1;
    release_seq(32'h2, 2);
    chk("fault on spare", 1, route.spare_io);
    chk("fault relay freed", 0, fault_relay);
    chk("slow brake open", 1, brake_slow);
    ahb(1'b0, mbs_pkg::MBS_OFF_CTRL, 32'h0);
    chk("open flag", 1, rd[mbs_pkg::MBS_CTRL_OPEN_BIT]);
    set_m(16'h0005, 16'h0064, 1'b1, 1'b0);
    wait_route(2, 1'b0, 5);
    chk("current loss applies", 0, route.relay);
    idle();
  endtask

  // secure safe input keeps the relay for faults
  task automatic t_secure;
    release_seq(32'h12, 0);
    ahb(1'b0, mbs_pkg::MBS_OFF_CTRL, 32'h0);
    chk("selector to user", 32'h3, {30'h0, rd[1:0]});
    chk("relay keeps fault", 1, fault_relay);
    chk("relay not brake", 0, route.relay);
    chk("no contactor", 0, route.contactor);
    idle();
    @(posedge i_clk);
    fault <= 1'b0;
  endtask

  task automatic t_abandon;
    ahb(1'b1, mbs_pkg::MBS_OFF_CTRL, 32'h1);
    set_m(16'h0064, 16'h0064, 1'b1, 1'b0);
    repeat (4) @(posedge i_clk);
    set_m(16'h0064, 16'h0064, 1'b1, 1'b1);
    repeat (40) @(posedge i_clk);
    chk("abandoned release", 0, route.contactor);
    chk("brake stays shut", 0, brake_fast);
    idle();
  endtask

  task automatic t_mode;
    ahb(1'b1, mbs_pkg::MBS_OFF_FRQ_APL, 32'h7);
    ahb(1'b1, mbs_pkg::MBS_OFF_DLY_MAG, 32'h9);
    ahb(1'b1, mbs_pkg::MBS_OFF_CTRL, 32'h101);
    ahb(1'b0, mbs_pkg::MBS_OFF_FRQ_APL, 32'h0);
    chk("apply freq factory", {16'h0, mbs_pkg::MBS_RST_FRQ_APL}, rd);
    ahb(1'b0, mbs_pkg::MBS_OFF_DLY_MAG, 32'h0);
    chk("mag delay factory", {16'h0, mbs_pkg::MBS_RST_DLY_MAG}, rd);
    ahb(1'b1, mbs_pkg::MBS_OFF_DLY_MAG, 32'h3);
    release_seq(32'h101, 3);
    set_m(16'h0064, 16'h0005, 1'b1, 1'b1);
    repeat (4) @(posedge i_clk);
    chk("pre-release holds cmd", 1, route.contactor);
    wait_route(3, 1'b0, 40);
    chk("pre-release then apply", 0, route.contactor);
    // closed vector to servo stays in one loop family: settings must survive
    ahb(1'b1, mbs_pkg::MBS_OFF_FRQ_APL, 32'h7);
    ahb(1'b1, mbs_pkg::MBS_OFF_CTRL, 32'h201);
    ahb(1'b0, mbs_pkg::MBS_OFF_FRQ_APL, 32'h0);
    chk("apply freq kept", 32'h7, rd);
    ahb(1'b0, mbs_pkg::MBS_OFF_CTRL, 32'h0);
    chk("servo mode stored", 32'h2, {30'h0, rd[mbs_pkg::MBS_CTRL_MODE_LSB +: 2]});
  endtask

  initial begin
    hsel   = 1'b0;
    hwrite = 1'b0;
    haddr  = 8'h00;
    htrans = 2'b00;
    hsize  = 3'b010;
    hwdata = 32'h0;
    fault  = 1'b0;
    meas   = '0;
    repeat (10) @(posedge i_clk);
    i_rst_b <= 1'b1;
    ahb(1'b0, mbs_pkg::MBS_OFF_CUR_UP, 32'h0);
    chk("upper current reset", {16'h0, mbs_pkg::MBS_RST_CUR_UP}, rd);
    ahb(1'b0, mbs_pkg::MBS_OFF_STATUS, 32'h0);
    chk("status reset", 32'h0, rd);
    ahb(1'b0, 8'h3C, 32'h0);
    chk("unmapped read", 32'h0, rd);
    // short delays keep the run small: 3 ms is 12 cycles here
    ahb(1'b1, mbs_pkg::MBS_OFF_DLY_MAG, 32'h3);
    ahb(1'b1, mbs_pkg::MBS_OFF_DLY_PST, 32'h3);
    ahb(1'b1, mbs_pkg::MBS_OFF_DLY_APL, 32'h3);
    t_off();
    t_cond();
    t_contact();
    t_relay();
    t_secure();
    t_abandon();
    t_mode();
    wrap_up();
  end
endmodule
`default_nettype wire
